// *** idv_pkg.sv ***
package idv_pkg;
  // ****************************************************************
  // divider constants
  // ****************************************************************
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned CALC_CYCLES = 8;    // cycles from start to done
  localparam int unsigned CNT_W       = 4;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam int unsigned IDX_DIVIDEND = 0;  // operand write select codes
  localparam int unsigned IDX_DIVISOR  = 1;
endpackage

// *** idv_divider.sv ***
// How it works
// - quotient truncates toward zero, remainder follows dividend
// - only the start pulse launches a division
// - done flag rises eight cycles after start
// - zero divisor at the last count sets error flag
// - operand writes land in one cycle
`timescale 1ns/100ps
`default_nettype none

module idv_divider
  import idv_pkg::*;
#(
  parameter int unsigned LATENCY = CALC_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr_en,
  input  wire logic              wr_sel,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              start,
  input  wire logic              signed_mode,
  output logic      [DATA_W-1:0] dividend_q,
  output logic      [DATA_W-1:0] divisor_q,
  output logic      [DATA_W-1:0] quotient_q,
  output logic      [DATA_W-1:0] remainder_q,
  output logic                   busy_q,
  output logic                   done_q,
  output logic                   dzero_q
);

  // ****************************************************************
  // operand registers
  // ****************************************************************

  // single-cycle operand load, no wait states
  always_ff @(posedge clk) begin
    if (rst) begin
      dividend_q <= RST_WORD;
      divisor_q  <= RST_WORD;
    end else if (wr_en) begin
      if (wr_sel == 1'(IDX_DIVISOR)) begin
        divisor_q <= wr_data;
      end else begin
        dividend_q <= wr_data;
      end
    end
  end

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  logic [DATA_W-1:0] a_mag;
  logic [DATA_W-1:0] b_mag;
  logic [DATA_W-1:0] q_mag;
  logic [DATA_W-1:0] r_mag;
  logic              a_neg;
  logic              b_neg;
  logic              neg_q;
  logic              neg_r;
  logic [DATA_W-1:0] q_res;
  logic [DATA_W-1:0] r_res;

  // two's-complement negate on request; shared by both operands and both results
  function automatic logic [DATA_W-1:0] cond_neg(
    input logic              neg,
    input logic [DATA_W-1:0] val
  );
    cond_neg = neg ? -val : val;
  endfunction

  // magnitude divide then restore sign: truncation toward zero
  always_comb begin
    a_neg = signed_mode & dividend_q[DATA_W-1];
    b_neg = signed_mode & divisor_q[DATA_W-1];
    neg_q = a_neg ^ b_neg;
    neg_r = a_neg; // remainder takes the dividend sign
    a_mag = cond_neg(a_neg, dividend_q);
    b_mag = cond_neg(b_neg, divisor_q);
    if (b_mag == '0) begin
      q_mag = '0; // zero divisor: quotient 0, remainder keeps dividend
      r_mag = a_mag;
    end else begin
      q_mag = a_mag / b_mag;
      r_mag = a_mag % b_mag;
    end
    q_res = cond_neg(neg_q, q_mag);
    r_res = cond_neg(neg_r, r_mag);
  end

  // ****************************************************************
  // sequencing
  // ****************************************************************
  logic [CNT_W-1:0] cnt_q;

  // count latency; results and flags update on the last count
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q      <= 1'h0;
      done_q      <= 1'h0;
      dzero_q     <= 1'h0;
      cnt_q       <= '0;
      quotient_q  <= RST_WORD;
      remainder_q <= RST_WORD;
    end else if (start) begin
      busy_q  <= 1'h1;
      done_q  <= 1'h0;
      dzero_q <= 1'h0;
      cnt_q   <= CNT_W'(LATENCY - 32'h1);
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_q      <= 1'h0;
        done_q      <= 1'h1;
        dzero_q     <= (divisor_q == '0);
        quotient_q  <= q_res;
        remainder_q <= r_res;
      end else begin
        cnt_q <= cnt_q - 1'h1;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // most negative word, the one signed case whose quotient overflows
  localparam logic [DATA_W-1:0] MOST_NEG = {1'h1, {(DATA_W-1){1'h0}}};
  logic [CNT_W-1:0]  age_q;

  // edges since the last start, parked at latency once done, all ones after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      age_q <= '1;
    end else if (start) begin
      age_q <= '0;
    end else if (age_q < CNT_W'(LATENCY)) begin
      age_q <= age_q + 1'h1;
    end
  end

  // count timing
  chk_done_latency: assert property (@(posedge clk) disable iff (rst)
    start ##1 (!start && !rst) [*8] |=> done_q)
    else $error("done not raised eight cycles after start");

  chk_done_not_early: assert property (@(posedge clk) disable iff (rst)
    start |=> !done_q)
    else $error("done raised too early");

  chk_busy_window: assert property (@(posedge clk) disable iff (rst)
    (age_q < CNT_W'(LATENCY)) |-> (busy_q && !done_q))
    else $error("busy or done wrong during count");

  chk_done_sticky: assert property (@(posedge clk) disable iff (rst)
    (age_q == CNT_W'(LATENCY)) |-> (done_q && !busy_q))
    else $error("done not standing after count");

  chk_result_hold: assert property (@(posedge clk) disable iff (rst)
    (age_q == CNT_W'(LATENCY) && !start) |=>
      ($stable(quotient_q) && $stable(remainder_q) && $stable(dzero_q)))
    else $error("result changed without start");

  // launch control
  chk_no_spurious: assert property (@(posedge clk) disable iff (rst)
    (!busy_q && !start) |=> !busy_q)
    else $error("busy without start");

  chk_busy_start: assert property (@(posedge clk) disable iff (rst)
    start |=> busy_q)
    else $error("busy not raised by start");

  chk_idle_reset: assert property (@(posedge clk) disable iff (rst)
    (age_q == '1) |-> (!busy_q && !done_q && !dzero_q))
    else $error("activity before any start");

  // divide by zero
  chk_dzero_flag: assert property (@(posedge clk) disable iff (rst)
    $rose(done_q) |-> (dzero_q == ($past(divisor_q) == '0)))
    else $error("divide by zero flag mismatch");

  chk_dzero_clear: assert property (@(posedge clk) disable iff (rst)
    start |=> !dzero_q)
    else $error("error flag not cleared by start");

  chk_dzero_result: assert property (@(posedge clk) disable iff (rst)
    ($rose(done_q) && dzero_q) |-> (quotient_q == '0))
    else $error("quotient not zero on zero divisor");

  // operand loads
  chk_operand_load: assert property (@(posedge clk) disable iff (rst)
    (wr_en && wr_sel) |=> (divisor_q == $past(wr_data)))
    else $error("divisor not loaded in one cycle");

  chk_dividend_load: assert property (@(posedge clk) disable iff (rst)
    (wr_en && !wr_sel) |=> (dividend_q == $past(wr_data)))
    else $error("dividend not loaded in one cycle");

  // quotient and remainder values
  chk_trunc_zero: assert property (@(posedge clk) disable iff (rst)
    ($rose(done_q) && !dzero_q && signed_mode && !$past(wr_en)) |->
      ((quotient_q[DATA_W-1] == (dividend_q[DATA_W-1] ^ divisor_q[DATA_W-1]))
       || quotient_q == '0 || quotient_q == MOST_NEG))
    else $error("signed quotient sign wrong");

  chk_rem_sign: assert property (@(posedge clk) disable iff (rst)
    ($rose(done_q) && !dzero_q && signed_mode && !$past(wr_en)) |->
      (remainder_q == '0 || remainder_q[DATA_W-1] == dividend_q[DATA_W-1]))
    else $error("signed remainder sign wrong");

  chk_signed_min: assert property (@(posedge clk) disable iff (rst)
    ($rose(done_q) && signed_mode && !$past(wr_en)
     && dividend_q == MOST_NEG && divisor_q == '1) |->
      (quotient_q == MOST_NEG && remainder_q == '0))
    else $error("signed overflow case wrong");

  chk_unsigned_q: assert property (@(posedge clk) disable iff (rst)
    ($rose(done_q) && !dzero_q && !signed_mode && !$past(wr_en)) |->
      (quotient_q == dividend_q / divisor_q))
    else $error("unsigned quotient wrong");

  chk_unsigned_r: assert property (@(posedge clk) disable iff (rst)
    ($rose(done_q) && !dzero_q && !signed_mode && !$past(wr_en)) |->
      (remainder_q == dividend_q % divisor_q))
    else $error("unsigned remainder wrong");

endmodule

`default_nettype wire

// *** test_idv_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_idv_divider
  import idv_pkg::*;
;
  // ****************
  // stimulus, checks
  // ****************
  logic              clk = 1'h0, rst = 1'h1, wr_en = 1'h0, wr_sel = 1'h0;
  logic              start = 1'h0, signed_mode = 1'h0, busy, done, dz;
  logic [DATA_W-1:0] wr_data = 32'h0, dvd, dvs, quo, rem;
  int                n_errors = 0, compares = 0;
  // free-running clock
  always #20 clk = ~clk;
  idv_divider i_dut (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .start(start), .signed_mode(signed_mode), .dividend_q(dvd), .divisor_q(dvs),
    .quotient_q(quo), .remainder_q(rem), .busy_q(busy), .done_q(done), .dzero_q(dz));
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one operand write, strobe dropped a cycle later
  task wr(input logic s, input logic [31:0] d);
    @(negedge clk); wr_en = 1'h1; wr_sel = s; wr_data = d;
    @(negedge clk); wr_en = 1'h0;
  endtask
  // start pulse, then follow the count to done
  task launch;
    start = 1'h1;
    @(negedge clk); start = 1'h0;
    chk(busy, 32'h1);
    repeat (7) @(negedge clk);
    chk(done, 32'h0);
    @(negedge clk);
    chk(done, 32'h1);
    chk(busy, 32'h0);
  endtask
  // load both operands, pick the mode and launch
  task go(input logic [31:0] a, input logic [31:0] b, input logic s);
    wr(1'h0, a); wr(1'h1, b);
    signed_mode = s;
    launch;
  endtask
  // back-to-back writes, no launch without start
  task t_load;
    @(negedge clk); wr_en = 1'h1; wr_sel = 1'h0; wr_data = 32'h0000_1234;
    @(negedge clk); wr_sel = 1'h1; wr_data = 32'h0000_0005;
    chk(dvd, 32'h0000_1234);
    @(negedge clk); wr_en = 1'h0;
    chk(dvs, 32'h0000_0005);
    repeat (10) @(negedge clk);
    chk(done, 32'h0);
    chk(busy, 32'h0);
    $display("test load done");
  endtask
  task t_zero;
    go(32'h9, 32'h0, 1'h0);
    chk(dz, 32'h1);
    chk(quo, 32'h0);
    chk(rem, 32'h9);
    $display("test zero done");
  endtask
  task t_signed;
    go(32'hffff_fff9, 32'h2, 1'h1);
    chk(dz, 32'h0);
    chk(quo, 32'hffff_fffd);
    chk(rem, 32'hffff_ffff);
    $display("test signed done");
  endtask
  task t_unsigned;
    go(32'hffff_fff9, 32'h2, 1'h0);
    chk(quo, 32'h7fff_fffc);
    chk(rem, 32'h1);
    $display("test unsigned done");
  endtask
  // relaunch mid-count on the overflow case; done counts from the second start
  task t_restart;
    wr(1'h0, 32'h8000_0000); wr(1'h1, 32'hffff_ffff);
    signed_mode = 1'h1; start = 1'h1;
    @(negedge clk); start = 1'h0;
    repeat (3) @(negedge clk);
    launch;
    chk(dz, 32'h0);
    chk(quo, 32'h8000_0000);
    chk(rem, 32'h0);
    $display("test restart done");
  endtask
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    t_load; t_zero; t_signed; t_unsigned; t_restart;
    end_of_test;
  end
  // watchdog
  initial begin
    #20000;
    n_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
